// ==== shared/mrsa_map.svh ====
// register offsets, field positions and reset values of the alu block
`ifndef MRSA_MAP_SVH
`define MRSA_MAP_SVH

`define MRSA_OFS_OPCTL   8'h00
`define MRSA_OFS_MEMIN   8'h04
`define MRSA_OFS_IMM     8'h08
`define MRSA_OFS_WORK    8'h0c
`define MRSA_OFS_FLAGS   8'h10
`define MRSA_OFS_STATUS  8'h14

`define MRSA_OP_LSB      0
`define MRSA_OP_MSB      4
`define MRSA_BIT_LSB     8
`define MRSA_BIT_MSB     10

`define MRSA_FLAG_C      0
`define MRSA_FLAG_HALF_BORROW   1
`define MRSA_FLAG_Z      2
`define MRSA_FLAG_SIGNED_RANGE  3

`define MRSA_ST_BUSY     0
`define MRSA_ST_SKIP     1
`define MRSA_ST_MEMWR    2

`define MRSA_RST_BYTE    8'h00
`define MRSA_RST_FLAG    1'b0
`define MRSA_RST_WORD    32'h0000_0000

`endif

// ==== shared/mrsa_pkg.sv ====
// types of the rotate, subtract and skip alu block
package mrsa_pkg;

    typedef logic [31:0] mrsa_word_t;
    typedef logic [7:0]  mrsa_byte_t;

    typedef enum logic [4:0] {
        OP_NOP                     = 5'h00,
        OP_ROTL_IN_PLACE           = 5'h01,
        OP_ROTL_TO_WORK            = 5'h02,
        OP_ROTL_THROUGH_CARRY      = 5'h03,
        OP_ROTL_THROUGH_CARRY_WORK = 5'h04,
        OP_ROTR_IN_PLACE           = 5'h05,
        OP_ROTR_TO_WORK            = 5'h06,
        OP_ROTR_THROUGH_CARRY      = 5'h07,
        OP_ROTR_THROUGH_CARRY_WORK = 5'h08,
        OP_MINUS_BORROW_WORK       = 5'h09,
        OP_MINUS_BORROW_MEM        = 5'h0a,
        OP_MINUS_WORK              = 5'h0b,
        OP_MINUS_TO_MEM            = 5'h0c,
        OP_MINUS_IMM               = 5'h0d,
        OP_DEC_SKIP_ZERO           = 5'h0e,
        OP_DEC_SKIP_ZERO_WORK      = 5'h0f,
        OP_INC_SKIP_ZERO           = 5'h10,
        OP_INC_SKIP_ZERO_WORK      = 5'h11,
        OP_BIT_SKIP_SET            = 5'h12,
        OP_SKIP_IF_ZERO            = 5'h13,
        OP_MOVE_SKIP_ZERO          = 5'h14,
        OP_BYTE_FILL               = 5'h15,
        OP_BIT_SET                 = 5'h16,
        OP_NIBBLE_EXCHANGE         = 5'h17,
        OP_NIBBLE_EXCHANGE_WORK    = 5'h18
    } mrsa_op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_DUMMY = 3'b100
    } mrsa_state_t;

endpackage : mrsa_pkg

// ==== core/mrsa_core.sv ====
// rotate, subtract and skip alu datapath with an ahb-lite register slave
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mrsa_map.svh"

module mrsa_core (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire mrsa_pkg::mrsa_word_t hwdata,
    output var  mrsa_pkg::mrsa_word_t hrdata,
    output logic                   hreadyout,
    output logic                   hresp
);
    import mrsa_pkg::*;

    mrsa_state_t state_reg;
    mrsa_op_t    op_reg;
    logic [2:0]  bit_reg;
    mrsa_byte_t  mem_reg;
    mrsa_byte_t  imm_reg;
    mrsa_byte_t  work_reg;
    logic        c_reg;
    logic        half_borrow_flag_reg;
    logic        z_reg;
    logic        signed_range_flag_reg;
    logic        skip_reg;
    logic        memwr_reg;
    mrsa_word_t  hrdata_reg;
    logic        hreadyout_reg;
    logic        hresp_reg;
    logic        dp_write_reg;
    logic [7:0]  dp_addr_reg;

    // alu combinational results
    mrsa_byte_t  alu_res;
    logic        to_work;
    logic        to_mem;
    logic        c_upd;
    logic        c_new;
    logic        arith;
    logic        skip_hit;
    mrsa_byte_t  sub_b;
    logic        sub_cin;
    logic [8:0]  diff9;
    logic [4:0]  diff_lo;
    logic        exec_now;
    logic        start_op;
    logic        wr_ok;

    function automatic logic is_skip_op(input mrsa_op_t o);
        is_skip_op = (o == OP_DEC_SKIP_ZERO) || (o == OP_DEC_SKIP_ZERO_WORK)
                  || (o == OP_INC_SKIP_ZERO) || (o == OP_INC_SKIP_ZERO_WORK)
                  || (o == OP_BIT_SKIP_SET) || (o == OP_SKIP_IF_ZERO)
                  || (o == OP_MOVE_SKIP_ZERO);
    endfunction

    function automatic logic is_borrow_op(input mrsa_op_t o);
        is_borrow_op = (o == OP_MINUS_BORROW_WORK)
                    || (o == OP_MINUS_BORROW_MEM);
    endfunction

    function automatic mrsa_byte_t bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

    assign exec_now = (state_reg == ST_EXEC);
    assign wr_ok    = dp_write_reg;
    assign start_op = wr_ok && (dp_addr_reg == `MRSA_OFS_OPCTL)
                   && (state_reg == ST_IDLE);

    // one subtractor serves all five subtract forms
    assign sub_b   = (op_reg == OP_MINUS_IMM) ? imm_reg : mem_reg;
    assign sub_cin = is_borrow_op(op_reg) ? ~c_reg : 1'b0;
    assign diff9   = {1'b0, work_reg} - {1'b0, sub_b} - {8'h00, sub_cin};
    assign diff_lo = {1'b0, work_reg[3:0]} - {1'b0, sub_b[3:0]}
                   - {4'h0, sub_cin};

    always_comb begin
        alu_res  = 8'h00;
        to_work  = 1'b0;
        to_mem   = 1'b0;
        c_upd    = 1'b0;
        c_new    = c_reg;
        arith    = 1'b0;
        skip_hit = 1'b0;
        unique case (op_reg)
            OP_ROTL_IN_PLACE: begin
                alu_res = {mem_reg[6:0], mem_reg[7]};
                to_mem  = 1'b1;
            end
            OP_ROTL_TO_WORK: begin
                alu_res = {mem_reg[6:0], mem_reg[7]};
                to_work = 1'b1;
            end
            OP_ROTL_THROUGH_CARRY: begin
                alu_res = {mem_reg[6:0], c_reg};
                to_mem  = 1'b1;
                c_upd   = 1'b1;
                c_new   = mem_reg[7];
            end
            OP_ROTL_THROUGH_CARRY_WORK: begin
                alu_res = {mem_reg[6:0], c_reg};
                to_work = 1'b1;
                c_upd   = 1'b1;
                c_new   = mem_reg[7];
            end
            OP_ROTR_IN_PLACE: begin
                alu_res = {mem_reg[0], mem_reg[7:1]};
                to_mem  = 1'b1;
            end
            OP_ROTR_TO_WORK: begin
                alu_res = {mem_reg[0], mem_reg[7:1]};
                to_work = 1'b1;
            end
            OP_ROTR_THROUGH_CARRY: begin
                alu_res = {c_reg, mem_reg[7:1]};
                to_mem  = 1'b1;
                c_upd   = 1'b1;
                c_new   = mem_reg[0];
            end
            OP_ROTR_THROUGH_CARRY_WORK: begin
                alu_res = {c_reg, mem_reg[7:1]};
                to_work = 1'b1;
                c_upd   = 1'b1;
                c_new   = mem_reg[0];
            end
            OP_MINUS_BORROW_WORK, OP_MINUS_WORK, OP_MINUS_IMM: begin
                alu_res = diff9[7:0];
                to_work = 1'b1;
                arith   = 1'b1;
            end
            OP_MINUS_BORROW_MEM, OP_MINUS_TO_MEM: begin
                alu_res = diff9[7:0];
                to_mem  = 1'b1;
                arith   = 1'b1;
            end
            OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_WORK: begin
                alu_res  = mem_reg - 8'h01;
                to_mem   = (op_reg == OP_DEC_SKIP_ZERO);
                to_work  = (op_reg == OP_DEC_SKIP_ZERO_WORK);
                skip_hit = (mem_reg == 8'h01);
            end
            OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_WORK: begin
                alu_res  = mem_reg + 8'h01;
                to_mem   = (op_reg == OP_INC_SKIP_ZERO);
                to_work  = (op_reg == OP_INC_SKIP_ZERO_WORK);
                skip_hit = (mem_reg == 8'hff);
            end
            OP_BIT_SKIP_SET: begin
                skip_hit = |(mem_reg & bit_mask(bit_reg));
            end
            OP_SKIP_IF_ZERO: begin
                skip_hit = (mem_reg == 8'h00);
            end
            OP_MOVE_SKIP_ZERO: begin
                alu_res  = mem_reg;
                to_work  = 1'b1;
                skip_hit = (mem_reg == 8'h00);
            end
            OP_BYTE_FILL: begin
                alu_res = 8'hff;
                to_mem  = 1'b1;
            end
            OP_BIT_SET: begin
                alu_res = mem_reg | bit_mask(bit_reg);
                to_mem  = 1'b1;
            end
            OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_WORK: begin
                alu_res = {mem_reg[3:0], mem_reg[7:4]};
                to_mem  = (op_reg == OP_NIBBLE_EXCHANGE);
                to_work = (op_reg == OP_NIBBLE_EXCHANGE_WORK);
            end
            default: begin
            end
        endcase
    end

    // sequencer: the skip forms hold busy one extra cycle for the dummy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE:  state_reg <= start_op ? ST_EXEC : ST_IDLE;
                ST_EXEC:  state_reg <= is_skip_op(op_reg) ? ST_DUMMY
                                                          : ST_IDLE;
                ST_DUMMY: state_reg <= ST_IDLE;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    // command latch; a write while busy is dropped so operands stay coherent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_reg  <= OP_NOP;
            bit_reg <= 3'h0;
        end else if (start_op) begin
            op_reg  <= mrsa_op_t'(hwdata[`MRSA_OP_MSB:`MRSA_OP_LSB]);
            bit_reg <= hwdata[`MRSA_BIT_MSB:`MRSA_BIT_LSB];
        end
    end

    // datapath results win over a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_reg <= `MRSA_RST_BYTE;
        end else if (exec_now && to_mem) begin
            mem_reg <= alu_res;
        end else if (wr_ok && dp_addr_reg == `MRSA_OFS_MEMIN) begin
            mem_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            work_reg <= `MRSA_RST_BYTE;
        end else if (exec_now && to_work) begin
            work_reg <= alu_res;
        end else if (wr_ok && dp_addr_reg == `MRSA_OFS_WORK) begin
            work_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imm_reg <= `MRSA_RST_BYTE;
        end else if (wr_ok && dp_addr_reg == `MRSA_OFS_IMM) begin
            imm_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c_reg                 <= `MRSA_RST_FLAG;
            half_borrow_flag_reg  <= `MRSA_RST_FLAG;
            z_reg                 <= `MRSA_RST_FLAG;
            signed_range_flag_reg <= `MRSA_RST_FLAG;
        end else if (exec_now && arith) begin
            c_reg                 <= ~diff9[8];
            half_borrow_flag_reg  <= diff_lo[4];
            z_reg                 <= (diff9[7:0] == 8'h00);
            signed_range_flag_reg <= (work_reg[7] != sub_b[7])
                                  && (diff9[7] != work_reg[7]);
        end else if (exec_now && c_upd) begin
            c_reg                 <= c_new;
        end else if (wr_ok && dp_addr_reg == `MRSA_OFS_FLAGS) begin
            c_reg                 <= hwdata[`MRSA_FLAG_C];
            half_borrow_flag_reg  <= hwdata[`MRSA_FLAG_HALF_BORROW];
            z_reg                 <= hwdata[`MRSA_FLAG_Z];
            signed_range_flag_reg <= hwdata[`MRSA_FLAG_SIGNED_RANGE];
        end
    end

    // outcome of the last operation, cleared when the next one starts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            skip_reg  <= 1'b0;
            memwr_reg <= 1'b0;
        end else if (start_op) begin
            skip_reg  <= 1'b0;
            memwr_reg <= 1'b0;
        end else if (exec_now) begin
            skip_reg  <= skip_hit;
            memwr_reg <= to_mem;
        end
    end

    // ahb-lite address phase; reads take one wait state so that a write
    // in the preceding data phase is visible, unless it was dropped while busy or lost to a datapath result
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 8'h00;
        end else if (hready) begin
            dp_write_reg <= hsel && htrans[1] && hwrite;
            dp_addr_reg  <= haddr[7:0];
        end else begin
            dp_write_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= `MRSA_RST_WORD;
            hresp_reg     <= 1'b0;
        end else if (hready && hreadyout_reg && hsel && htrans[1]
                     && !hwrite) begin
            // drop ready at the address edge so the first data-phase
            // cycle of a read is already a wait state
            hreadyout_reg <= 1'b0;
        end else if (!hreadyout_reg) begin
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= 32'h0000_0000;
            unique case (dp_addr_reg)
                `MRSA_OFS_OPCTL: begin
                    hrdata_reg[`MRSA_OP_MSB:`MRSA_OP_LSB]   <= op_reg;
                    hrdata_reg[`MRSA_BIT_MSB:`MRSA_BIT_LSB] <= bit_reg;
                end
                `MRSA_OFS_MEMIN: hrdata_reg[7:0] <= mem_reg;
                `MRSA_OFS_IMM:   hrdata_reg[7:0] <= imm_reg;
                `MRSA_OFS_WORK:  hrdata_reg[7:0] <= work_reg;
                `MRSA_OFS_FLAGS: begin
                    hrdata_reg[`MRSA_FLAG_C] <= c_reg;
                    hrdata_reg[`MRSA_FLAG_HALF_BORROW] <=
                        half_borrow_flag_reg;
                    hrdata_reg[`MRSA_FLAG_Z] <= z_reg;
                    hrdata_reg[`MRSA_FLAG_SIGNED_RANGE] <=
                        signed_range_flag_reg;
                end
                `MRSA_OFS_STATUS: begin
                    hrdata_reg[`MRSA_ST_BUSY]  <= (state_reg != ST_IDLE);
                    hrdata_reg[`MRSA_ST_SKIP]  <= skip_reg;
                    hrdata_reg[`MRSA_ST_MEMWR] <= memwr_reg;
                end
                default: begin
                end
            endcase
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = hresp_reg;

    // checks
    sequence s_exec(mrsa_op_t o);
        exec_now && (op_reg == o);
    endsequence

    sequence s_flags_kept;
        c_reg == $past(c_reg) && z_reg == $past(z_reg)
        && half_borrow_flag_reg == $past(half_borrow_flag_reg)
        && signed_range_flag_reg == $past(signed_range_flag_reg);
    endsequence

    a_rotl_work_value:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_ROTL_TO_WORK) |=> (work_reg ==
        {$past(mem_reg[6:0]), $past(mem_reg[7])}) ##0 s_flags_kept)
    else $error("rotate left to work gave a wrong byte or moved a flag");

    a_rotl_work_mem:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_ROTL_TO_WORK) |=> mem_reg == $past(mem_reg))
    else $error("rotate left to work changed the memory byte");

    a_rotl_carry_ring:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_ROTL_THROUGH_CARRY) |=>
        mem_reg == {$past(mem_reg[6:0]), $past(c_reg)}
        && c_reg == $past(mem_reg[7]) && z_reg == $past(z_reg))
    else $error("left rotate through carry broke the ring");

    a_rotr_place_value:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_ROTR_IN_PLACE) |=>
        (mem_reg == {$past(mem_reg[0]), $past(mem_reg[7:1])}) ##0 s_flags_kept)
    else $error("rotate right in place gave a wrong byte");

    a_rotr_carry_ring:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_ROTR_THROUGH_CARRY) |=>
        mem_reg == {$past(c_reg), $past(mem_reg[7:1])}
        && c_reg == $past(mem_reg[0]))
    else $error("right rotate through carry broke the ring");

    a_borrow_carry_out:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_MINUS_BORROW_WORK) |=> c_reg == ({1'b0, $past(work_reg)}
        >= ({1'b0, $past(mem_reg)} + {8'h00, ~$past(c_reg)})))
    else $error("carry after subtract with borrow is wrong");

    a_minus_imm_value:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_MINUS_IMM) |=> work_reg == $past(work_reg) - $past(imm_reg)
        && z_reg == ($past(work_reg) == $past(imm_reg)))
    else $error("immediate subtract gave a wrong result");

    a_dec_skip_mem:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_DEC_SKIP_ZERO) |=> mem_reg == $past(mem_reg) - 8'h01
        && skip_reg == ($past(mem_reg) == 8'h01))
    else $error("decrement and skip wrote or skipped wrongly");

    a_skip_two_cycles:
    assert property (@(posedge hclk) disable iff (!hresetn)
        exec_now && is_skip_op(op_reg) |=>
        state_reg == ST_DUMMY ##1 state_reg == ST_IDLE)
    else $error("skip operation did not take two cycles");

    a_bit_set_only:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_BIT_SET) |=>
        mem_reg == ($past(mem_reg) | (8'h01 << $past(bit_reg))))
    else $error("bit set touched other bits");

    a_nibble_work:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s_exec(OP_NIBBLE_EXCHANGE_WORK) |=>
        work_reg == {$past(mem_reg[3:0]), $past(mem_reg[7:4])}
        && mem_reg == $past(mem_reg))
    else $error("nibble exchange to work is wrong");

endmodule // mrsa_core
`default_nettype wire

// ==== testbench/mrsa_host.sv ====
// bus master model standing in for the core decoder and sequencer
`timescale 1ns/1ns
`default_nettype none
module mrsa_host
    import mrsa_pkg::*;
(
    input  wire logic                 hclk,
    input  wire logic                 hreadyout,
    input  wire mrsa_pkg::mrsa_word_t hrdata,
    output logic                      hsel,
    output logic [31:0]               haddr,
    output logic [1:0]                htrans,
    output logic                      hwrite,
    output logic [2:0]                hsize,
    output var  mrsa_pkg::mrsa_word_t hwdata
);
    initial begin
        hsel   = 1'h0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // entered just after a rising edge; every wait is on hreadyout itself
    task automatic xfer(input logic w, input logic [7:0] a,
                        input mrsa_word_t d, output mrsa_word_t q);
        hsel   <= 1'h1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        q = hrdata;
    endtask
endmodule // mrsa_host
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench of the alu register slave, random and corner operands
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) check_count++; if ((s) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end
module tb;
    import mrsa_pkg::*;
    logic       hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    mrsa_word_t  hwdata, hrdata, q;
    int          error_cnt, check_count;
    logic [7:0]  m, w, im;
    logic [3:0]  f;
    logic [2:0]  b;
    logic [4:0]  op;
    logic [20:0] e;
    logic        mw;

    mrsa_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    mrsa_host host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    // result packed as {skip, flags, work, memory}; flags from bit 3 down:
    // signed range, zero, half borrow, carry
    function automatic logic [20:0] model(logic [4:0] op, logic [2:0] b,
        logic [7:0] m, logic [7:0] w, logic [7:0] imm, logic [3:0] f);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] s;
        logic       sk, bin;
        sk = 1'h0; s = m; bin = 1'h0;
        case (op)
            5'h01: m = {m[6:0], m[7]};
            5'h02: w = {m[6:0], m[7]};
            5'h03: begin m = {m[6:0], f[0]}; f[0] = s[7]; end
            5'h04: begin w = {m[6:0], f[0]}; f[0] = m[7]; end
            5'h05: m = {m[0], m[7:1]};
            5'h06: w = {m[0], m[7:1]};
            5'h07: begin m = {f[0], m[7:1]}; f[0] = s[0]; end
            5'h08: begin w = {f[0], m[7:1]}; f[0] = m[0]; end
            5'h0e: begin m = m - 8'h1; sk = (m == 8'h0); end
            5'h0f: begin w = m - 8'h1; sk = (w == 8'h0); end
            5'h10: begin m = m + 8'h1; sk = (m == 8'h0); end
            5'h11: begin w = m + 8'h1; sk = (w == 8'h0); end
            5'h12: sk = m[b];
            5'h13: sk = (m == 8'h0);
            5'h14: begin w = m; sk = (m == 8'h0); end
            5'h15: m = 8'hff;
            5'h16: m[b] = 1'h1;
            5'h17: m = {m[3:0], m[7:4]};
            5'h18: w = {m[3:0], m[7:4]};
            5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d: begin
                if (op == 5'h0d) s = imm;
                if (op < 5'h0b) bin = ~f[0];
                d = {1'h0, w} - {1'h0, s} - {8'h0, bin};
                h = {1'h0, w[3:0]} - {1'h0, s[3:0]} - {4'h0, bin};
                f = {(w[7] ^ s[7]) & (d[7] ^ w[7]), d[7:0] == 8'h0,
                     h[4], ~d[8]};
                if (op == 5'h0a || op == 5'h0c) m = d[7:0];
                else w = d[7:0];
            end
            default: ;
        endcase
        return {sk, f, w, m};
    endfunction

    task automatic wr(input logic [7:0] a, input mrsa_word_t d);
        host.xfer(1'h1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a);
        host.xfer(1'h0, a, 32'h0, q);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        hclk = 1'h0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        repeat (30000) @(posedge hclk);
        error_cnt++;
        tally_and_finish;
    end

    initial begin
        hresetn = 1'h0;
        error_cnt = 0;
        check_count = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        void'($urandom(65));
        @(posedge hclk);
        rd(8'h0c);
        `CHK("work rst", 32'h0, q)
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18);
        `CHK("unmapped", 32'h0, q)
        for (int i = 0; i < 75; i++) begin
            op = (i == 74) ? 5'h1f : 5'(i % 25);
            m = 8'($urandom);
            // wrap and zero corners for the skip and subtract paths
            if (i % 4 == 1) m = 8'hff;
            if (i % 4 == 2) m = 8'h01;
            if (i % 4 == 3) m = 8'h00;
            w = 8'($urandom);
            im = 8'($urandom);
            f = 4'($urandom);
            b = 3'($urandom);
            e = model(op, b, m, w, im, f);
            wr(8'h04, {24'h0, m});
            wr(8'h0c, {24'h0, w});
            wr(8'h08, {24'h0, im});
            wr(8'h10, {28'h0, f});
            wr(8'h00, {21'h0, b, 3'h0, op});
            rd(8'h14);
            `CHK("busy", op >= 5'h0e && op <= 5'h14, q[0])
            for (int n = 0; n < 20 && q[0] !== 1'h0; n++) rd(8'h14);
            `CHK("idle", 1'h0, q[0])
            mw = op inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h0a, 5'h0c,
                            5'h0e, 5'h10, 5'h15, 5'h16, 5'h17};
            `CHK("memwr", mw, q[2])
            `CHK("skip", e[20], q[1])
            rd(8'h0c);
            `CHK("work", {24'h0, e[15:8]}, q)
            rd(8'h04);
            `CHK("mem", {24'h0, e[7:0]}, q)
            rd(8'h10);
            `CHK("flags", {28'h0, e[19:16]}, q)
        end
        `CHK("hresp", 1'h0, hresp)
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
